//--- hw/eicl_pkg.sv
package eicl_pkg;

  // Timing
  localparam int EICL_CLK_NS = 8;
  // Each SCL phase (high is two phases, low is one)
  // Short phase keeps a nine-byte load brief; SCL low 1.5 us, high 3 us
  localparam int EICL_PHASE_NS = 1500;
  localparam int EICL_PHASE_CYC = (EICL_PHASE_NS + EICL_CLK_NS - 1) /
    EICL_CLK_NS;
  // Bus must stay free this long before the first START
  localparam int EICL_IDLE_NS = 20000;
  localparam int EICL_IDLE_CYC = (EICL_IDLE_NS + EICL_CLK_NS - 1) /
    EICL_CLK_NS;
  // Give up waiting for a free bus after this long
  localparam int EICL_BOOT_TIMEOUT_NS = 200000;
  localparam int EICL_BOOT_TIMEOUT_CYC = EICL_BOOT_TIMEOUT_NS / EICL_CLK_NS;

  // Addressing
  localparam logic [6:0] EICL_SLAVE_ADDR = 7'h50;
  localparam logic [7:0] EICL_WORD_ADDR = 8'h00;
  localparam logic [3:0] EICL_NUM_BYTES = 4'h9;
  localparam int EICL_IDS_W = 72;

  // Version word
  localparam logic [15:0] EICL_VER_LOADED = 16'h0100;
  localparam logic [15:0] EICL_VER_DEFAULT = 16'h0095;

  // Built-in identifiers; values are arbitrary
  localparam logic [15:0] EICL_DEF_VENDOR_ID = 16'h1a2b;
  localparam logic [15:0] EICL_DEF_DEVICE_ID = 16'h3c4d;
  localparam logic [15:0] EICL_DEF_SUB_VENDOR_ID = 16'h1a2b;
  localparam logic [15:0] EICL_DEF_SUB_DEVICE_ID = 16'h5e6f;
  localparam logic [7:0] EICL_DEF_CONFIG = 8'h00;

  typedef enum logic [1:0] {
    EICL_CMD_START,
    EICL_CMD_STOP,
    EICL_CMD_BIT
  } eicl_cmd_t;

  // EEPROM byte 0 lands in vendor_id[7:0], byte 8 in config_bits
  typedef struct packed {
    logic [7:0] config_bits;
    logic [15:0] sub_device_id;
    logic [15:0] sub_vendor_id;
    logic [15:0] device_id;
    logic [15:0] vendor_id;
  } eicl_ids_t;

endpackage : eicl_pkg

//--- hw/eicl_bit_engine.sv
`timescale 1ns/1ns
module eicl_bit_engine
  import eicl_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Synchronised line levels
  input wire logic scl_sync,
  input wire logic sda_sync,
  // Command
  input wire logic cmd_valid,
  input wire eicl_cmd_t cmd,
  input wire logic tx_bit,
  // Status
  output logic busy,
  output logic done,
  output logic rx_bit,
  // Line enables, low pulls the line down
  output logic scl_oe_n,
  output logic sda_oe_n
);

  logic [9:0] div_reg;
  logic [1:0] phase_reg;
  eicl_cmd_t cur_reg;
  logic tick;

  assign tick = busy && (div_reg == 10'(EICL_PHASE_CYC - 1));

  // Restart on accept so the first phase is full length
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      div_reg <= 10'h000;
    else if (cmd_valid || tick || !busy)
      div_reg <= 10'h000;
    else
      div_reg <= div_reg + 10'h001;
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      busy <= 1'b0;
      done <= 1'b0;
      rx_bit <= 1'b1;
      scl_oe_n <= 1'b1;
      sda_oe_n <= 1'b1;
      phase_reg <= 2'h0;
      cur_reg <= EICL_CMD_START;
    end
    else
    begin
      done <= 1'b0;
      if (cmd_valid && !busy)
      begin
        busy <= 1'b1;
        phase_reg <= 2'h0;
        cur_reg <= cmd;
        // SCL is low or free here, so SDA may change
        case (cmd)
          EICL_CMD_START: sda_oe_n <= 1'b1;
          EICL_CMD_STOP: sda_oe_n <= 1'b0;
          default: sda_oe_n <= tx_bit;
        endcase
      end
      else if (tick)
      begin
        case (phase_reg)
          2'h0:
          begin
            scl_oe_n <= 1'b1;
            phase_reg <= 2'h1;
          end
          2'h1:
          begin
            // A slave holding SCL low stretches the high phase
            if (scl_sync)
            begin
              case (cur_reg)
                EICL_CMD_START: sda_oe_n <= 1'b0;
                EICL_CMD_STOP: sda_oe_n <= 1'b1;
                default: rx_bit <= sda_sync;
              endcase
              phase_reg <= 2'h2;
            end
          end
          default:
          begin
            if (cur_reg != EICL_CMD_STOP)
              scl_oe_n <= 1'b0;
            busy <= 1'b0;
            done <= 1'b1;
            phase_reg <= 2'h0;
          end
        endcase
      end
    end
  end

endmodule : eicl_bit_engine

//--- hw/eicl_loader.sv
`timescale 1ns/1ns
// Contract
// - Fetch identifiers and config bits from EEPROM
// - Lines are open drain, pull low or release
// - Bus idle only when SDA and SCL high
// - START: SDA falls while SCL high
// - STOP: SDA rises while SCL high
// - SDA changes only while SCL low
// - START opens, STOP closes, begin when idle
// - Receiver pulls SDA low on ninth clock; loader leaves SDA high after the last byte
// - Slave address is 101 0000b always
// - No page mode, low address bits zero
// - No EEPROM: load built-in default identifiers
// - Version 0100h if loaded or SCL grounded
module eicl_loader
  import eicl_pkg::*;
#(
  parameter int BOOT_TIMEOUT_CYC = EICL_BOOT_TIMEOUT_CYC
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Serial clock pin
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_n,
  // Serial data pin
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  // Loaded configuration
  output eicl_ids_t ids,
  output logic [15:0] host_interface_version,
  output logic from_eeprom,
  output logic load_done
);

  typedef enum logic [2:0] {
    ST_BOOT,
    ST_START,
    ST_TXBIT,
    ST_TXACK,
    ST_RXBIT,
    ST_RXACK,
    ST_STOP,
    ST_DONE
  } eicl_state_t;

  typedef enum logic [1:0] {
    SG_WADDR,
    SG_WORD,
    SG_RADDR,
    SG_DATA
  } eicl_stage_t;

  eicl_state_t state_reg;
  eicl_stage_t stage_reg;
  logic scl_meta_reg;
  logic scl_sync_reg;
  logic sda_meta_reg;
  logic sda_sync_reg;
  logic [11:0] idle_cnt_reg;
  logic [15:0] boot_cnt_reg;
  logic pend_reg;
  logic cmd_valid_reg;
  eicl_cmd_t cmd_reg;
  logic tx_bit_reg;
  eicl_cmd_t cmd_next;
  logic tx_bit_next;
  logic [7:0] shift_reg;
  logic [2:0] bit_cnt_reg;
  logic [3:0] byte_cnt_reg;
  logic [EICL_IDS_W-1:0] buf_reg;
  logic absent_reg;
  logic strap_reg;
  logic last_byte;
  logic eng_busy;
  logic eng_done;
  logic eng_rx;

  assign last_byte = (byte_cnt_reg == EICL_NUM_BYTES - 4'h1);

  // Pins come from outside the clock domain
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      scl_meta_reg <= 1'b1;
      scl_sync_reg <= 1'b1;
      sda_meta_reg <= 1'b1;
      sda_sync_reg <= 1'b1;
    end
    else
    begin
      scl_meta_reg <= scl_i;
      scl_sync_reg <= scl_meta_reg;
      sda_meta_reg <= sda_i;
      sda_sync_reg <= sda_meta_reg;
    end
  end

  // Drive level is always low; only the enables move
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end
    else
    begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end
  end

  // Free-bus window, restarted by any low level
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      idle_cnt_reg <= 12'h000;
    else if (state_reg != ST_BOOT || !(scl_sync_reg && sda_sync_reg))
      idle_cnt_reg <= 12'h000;
    else
      idle_cnt_reg <= idle_cnt_reg + 12'h001;
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      boot_cnt_reg <= 16'h0000;
    else if (state_reg == ST_BOOT)
      boot_cnt_reg <= boot_cnt_reg + 16'h0001;
  end

  // Command for the bit engine in each bus state
  always_comb
  begin
    cmd_next = EICL_CMD_BIT;
    tx_bit_next = 1'b1;
    case (state_reg)
      ST_START: cmd_next = EICL_CMD_START;
      ST_STOP: cmd_next = EICL_CMD_STOP;
      ST_TXBIT: tx_bit_next = shift_reg[7];
      ST_RXACK: tx_bit_next = last_byte;
      default: tx_bit_next = 1'b1;
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      state_reg <= ST_BOOT;
      stage_reg <= SG_WADDR;
      pend_reg <= 1'b0;
      cmd_valid_reg <= 1'b0;
      cmd_reg <= EICL_CMD_START;
      tx_bit_reg <= 1'b1;
      shift_reg <= 8'h00;
      bit_cnt_reg <= 3'h0;
      byte_cnt_reg <= 4'h0;
      buf_reg <= '0;
      absent_reg <= 1'b0;
      strap_reg <= 1'b0;
    end
    else
    begin
      cmd_valid_reg <= 1'b0;
      case (state_reg)
        ST_BOOT:
        begin
          if (idle_cnt_reg == 12'(EICL_IDLE_CYC - 1))
          begin
            state_reg <= ST_START;
            stage_reg <= SG_WADDR;
          end
          else if (boot_cnt_reg == 16'(BOOT_TIMEOUT_CYC - 1))
          begin
            // Lines grounded or stuck: nothing to talk to
            absent_reg <= 1'b1;
            strap_reg <= !scl_sync_reg;
            state_reg <= ST_DONE;
          end
        end
        ST_DONE:
        begin
          pend_reg <= 1'b0;
        end
        default:
        begin
          if (!pend_reg && !eng_busy)
          begin
            cmd_valid_reg <= 1'b1;
            pend_reg <= 1'b1;
            cmd_reg <= cmd_next;
            tx_bit_reg <= tx_bit_next;
          end
          else if (eng_done)
          begin
            pend_reg <= 1'b0;
            case (state_reg)
              ST_START:
              begin
                // Low three address bits stay zero
                shift_reg <= {EICL_SLAVE_ADDR,
                  stage_reg == SG_RADDR};
                bit_cnt_reg <= 3'h0;
                state_reg <= ST_TXBIT;
              end
              ST_TXBIT:
              begin
                shift_reg <= {shift_reg[6:0], 1'b0};
                bit_cnt_reg <= bit_cnt_reg + 3'h1;
                if (bit_cnt_reg == 3'h7)
                  state_reg <= ST_TXACK;
              end
              ST_TXACK:
              begin
                if (eng_rx)
                begin
                  absent_reg <= 1'b1;
                  state_reg <= ST_STOP;
                end
                else
                begin
                  case (stage_reg)
                    SG_WADDR:
                    begin
                      shift_reg <= EICL_WORD_ADDR;
                      stage_reg <= SG_WORD;
                      state_reg <= ST_TXBIT;
                    end
                    SG_WORD:
                    begin
                      stage_reg <= SG_RADDR;
                      state_reg <= ST_START;
                    end
                    default:
                    begin
                      stage_reg <= SG_DATA;
                      byte_cnt_reg <= 4'h0;
                      state_reg <= ST_RXBIT;
                    end
                  endcase
                end
              end
              ST_RXBIT:
              begin
                shift_reg <= {shift_reg[6:0], eng_rx};
                bit_cnt_reg <= bit_cnt_reg + 3'h1;
                if (bit_cnt_reg == 3'h7)
                  state_reg <= ST_RXACK;
              end
              ST_RXACK:
              begin
                buf_reg <= {shift_reg,
                  buf_reg[EICL_IDS_W-1:8]};
                byte_cnt_reg <= byte_cnt_reg + 4'h1;
                state_reg <= last_byte ? ST_STOP : ST_RXBIT;
              end
              default:
              begin
                state_reg <= ST_DONE;
              end
            endcase
          end
        end
      endcase
    end
  end

  // Results change once, when the load ends
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      ids <= {EICL_DEF_CONFIG, EICL_DEF_SUB_DEVICE_ID,
        EICL_DEF_SUB_VENDOR_ID, EICL_DEF_DEVICE_ID, EICL_DEF_VENDOR_ID};
      host_interface_version <= EICL_VER_DEFAULT;
      from_eeprom <= 1'b0;
      load_done <= 1'b0;
    end
    else if (state_reg == ST_DONE && !load_done)
    begin
      load_done <= 1'b1;
      if (absent_reg)
      begin
        ids <= {EICL_DEF_CONFIG, EICL_DEF_SUB_DEVICE_ID,
          EICL_DEF_SUB_VENDOR_ID, EICL_DEF_DEVICE_ID,
          EICL_DEF_VENDOR_ID};
        host_interface_version <= strap_reg ? EICL_VER_LOADED :
          EICL_VER_DEFAULT;
        from_eeprom <= 1'b0;
      end
      else
      begin
        ids <= eicl_ids_t'(buf_reg);
        host_interface_version <= EICL_VER_LOADED;
        from_eeprom <= 1'b1;
      end
    end
  end

  eicl_bit_engine u_engine (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .scl_sync(scl_sync_reg),
    .sda_sync(sda_sync_reg),
    .cmd_valid(cmd_valid_reg),
    .cmd(cmd_reg),
    .tx_bit(tx_bit_reg),
    .busy(eng_busy),
    .done(eng_done),
    .rx_bit(eng_rx),
    .scl_oe_n(scl_oe_n),
    .sda_oe_n(sda_oe_n)
  );

endmodule : eicl_loader

//--- dv/eicl_loader_props.sv
`timescale 1ns/1ns
module eicl_loader_props
  import eicl_pkg::*;
#(
  parameter int BOOT_TIMEOUT_CYC = EICL_BOOT_TIMEOUT_CYC
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Serial lines
  input wire logic scl_i,
  input wire logic scl_o,
  input wire logic scl_oe_n,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_n,
  // Results
  input wire eicl_ids_t ids,
  input wire logic [15:0] host_interface_version,
  input wire logic from_eeprom,
  input wire logic load_done
);
  localparam eicl_ids_t DEF_IDS = {EICL_DEF_CONFIG, EICL_DEF_SUB_DEVICE_ID,
    EICL_DEF_SUB_VENDOR_ID, EICL_DEF_DEVICE_ID, EICL_DEF_VENDOR_ID};
  logic started_reg;
  logic [11:0] idle_cnt_reg;
  logic [16:0] cyc_reg;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  always_ff @(posedge clk_sys or negedge nrst)
    if (!nrst)
      started_reg <= 1'h0;
    else if (!sda_oe_n)
      started_reg <= 1'h1;

  // Raw wire levels; the design's own count lags by its synchroniser
  always_ff @(posedge clk_sys or negedge nrst)
    if (!nrst)
      idle_cnt_reg <= 12'h000;
    else if (!(scl_i && sda_i))
      idle_cnt_reg <= 12'h000;
    else if (idle_cnt_reg != 12'hfff)
      idle_cnt_reg <= idle_cnt_reg + 12'h001;

  always_ff @(posedge clk_sys or negedge nrst)
    if (!nrst)
      cyc_reg <= 17'h00000;
    else if (cyc_reg != 17'h1ffff)
      cyc_reg <= cyc_reg + 17'h00001;

  sequence start_seq;
    scl_oe_n && $past(scl_oe_n) && $fell(sda_oe_n);
  endsequence
  sequence stop_seq;
    scl_oe_n && $past(scl_oe_n) && $rose(sda_oe_n);
  endsequence

  drive_low_a: assert property (scl_o == 1'h0 && sda_o == 1'h0)
    else $error("line driven high");
  start_form_a: assert property (start_seq |->
    !sda_oe_n throughout (##[1:700] !scl_oe_n))
    else $error("start not followed by clock low");
  stop_hold_a: assert property (stop_seq |->
    (sda_oe_n && scl_oe_n) [*8])
    else $error("bus not left free after stop");
  idle_first_a: assert property ($fell(sda_oe_n) && !started_reg |->
    idle_cnt_reg >= 12'(EICL_IDLE_CYC))
    else $error("first start without free bus");
  no_clock_early_a: assert property (!started_reg |-> scl_oe_n)
    else $error("clock pulled before start");
  // START pulls SDA only two phases after the free-bus window ends
  boot_bound_a: assert property (!started_reg &&
    cyc_reg > BOOT_TIMEOUT_CYC + 2 * EICL_PHASE_CYC + 16 |-> load_done)
    else $error("no result after boot timeout");
  done_hold_a: assert property (load_done |=> load_done &&
    $stable(ids) && $stable(host_interface_version))
    else $error("results changed after load");
  default_ids_a: assert property (load_done && !from_eeprom |->
    ids == DEF_IDS)
    else $error("defaults not loaded");
  loaded_ver_a: assert property (from_eeprom |->
    host_interface_version == EICL_VER_LOADED)
    else $error("wrong version after load");
  no_traffic_a: assert property (!started_reg |-> !from_eeprom)
    else $error("eeprom flag without traffic");
endmodule : eicl_loader_props

bind eicl_loader eicl_loader_props #(
  .BOOT_TIMEOUT_CYC(BOOT_TIMEOUT_CYC)
) u_props (
  .clk_sys(clk_sys), .nrst(nrst), .scl_i(scl_i), .scl_o(scl_o),
  .scl_oe_n(scl_oe_n), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
  .ids(ids), .host_interface_version(host_interface_version),
  .from_eeprom(from_eeprom), .load_done(load_done)
);

//--- dv/eicl_eeprom_model.sv
`timescale 1ns/1ns
module eicl_eeprom_model
(
  // Bus wires
  input wire logic scl,
  input wire logic sda,
  // Answer own address, or stay silent
  input wire logic en,
  // Data line, low pulls down
  output logic sda_oe_n,
  // Observed traffic
  output logic [7:0] last_addr,
  output logic [7:0] word_addr,
  output logic [3:0] sent_cnt
);
  logic [7:0] b;
  logic [7:0] ptr;
  logic mack;

  task automatic get_byte(output logic [7:0] v);
    repeat (8)
    begin
      @(posedge scl);
      v = {v[6:0], sda};
    end
  endtask : get_byte

  // Changes only in the low phase; caller releases or drives next bit
  task automatic ack();
    @(negedge scl);
    #50 sda_oe_n = 1'h0;
    @(negedge scl);
    #50;
  endtask : ack

  initial
  begin
    sda_oe_n = 1'h1;
    ptr = 8'h00;
    forever
    begin
      @(negedge sda iff scl === 1'h1);
      sent_cnt = 4'h0;
      get_byte(b);
      last_addr = b;
      if (!en || b[7:1] != 7'h50)
        continue;
      ack();
      if (!b[0])
      begin
        sda_oe_n = 1'h1;
        get_byte(ptr);
        word_addr = ptr;
        ack();
        sda_oe_n = 1'h1;
      end
      else
        do
        begin
          b = 8'h5a ^ (ptr * 8'h13);
          for (int k = 7; k >= 0; k--)
          begin
            sda_oe_n = b[k];
            @(negedge scl);
            #50;
          end
          sda_oe_n = 1'h1;
          @(posedge scl);
          mack = !sda;
          ptr++;
          sent_cnt++;
          if (mack)
          begin
            @(negedge scl);
            #50;
          end
        end while (mack);
    end
  end
endmodule : eicl_eeprom_model

//--- dv/tb_eicl_loader.sv
`timescale 1ns/1ns
module tb_eicl_loader;
  import eicl_pkg::*;
  localparam int BOOT_CYC = 3000;
  localparam eicl_ids_t DEF_IDS = {EICL_DEF_CONFIG, EICL_DEF_SUB_DEVICE_ID,
    EICL_DEF_SUB_VENDOR_ID, EICL_DEF_DEVICE_ID, EICL_DEF_VENDOR_ID};
  logic clk_sys, nrst, m_en, scl_low, sda_low, traffic;
  logic scl_o, scl_oe_n, sda_o, sda_oe_n, m_sda_oe_n;
  logic from_eeprom, load_done;
  logic [15:0] host_interface_version;
  logic [7:0] last_addr, word_addr;
  logic [3:0] sent_cnt;
  eicl_ids_t ids;
  wire scl;
  wire sda;
  int error_cnt;
  int cmp_count;

  // Pull-ups on both wires
  assign scl = scl_oe_n & ~scl_low;
  assign sda = sda_oe_n & m_sda_oe_n & ~sda_low;

  eicl_loader #(
    .BOOT_TIMEOUT_CYC(BOOT_CYC)
  ) dut (
    .clk_sys(clk_sys), .nrst(nrst), .scl_i(scl), .scl_o(scl_o),
    .scl_oe_n(scl_oe_n), .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
    .ids(ids), .host_interface_version(host_interface_version),
    .from_eeprom(from_eeprom), .load_done(load_done)
  );

  eicl_eeprom_model u_eeprom (
    .scl(scl), .sda(sda), .en(m_en), .sda_oe_n(m_sda_oe_n),
    .last_addr(last_addr), .word_addr(word_addr), .sent_cnt(sent_cnt)
  );

  initial
  begin
    clk_sys = 1'h0;
    forever #4 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys or negedge nrst)
    if (!nrst)
      traffic <= 1'h0;
    else if (!sda_oe_n || !scl_oe_n)
      traffic <= 1'h1;

  task automatic chk(input string nm, input logic [71:0] got,
    input logic [71:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask : chk

  task automatic run_boot(input logic en, input logic sl, input logic dl,
    input int lim);
    @(posedge clk_sys);
    #1;
    nrst = 1'h0;
    m_en = en;
    scl_low = sl;
    sda_low = dl;
    repeat (20) @(posedge clk_sys);
    #1 nrst = 1'h1;
    for (int n = 0; n < lim && load_done !== 1'h1; n++)
    begin
      @(posedge clk_sys);
      #1;
    end
    chk("load_done", load_done, 1'h1);
  endtask : run_boot

  task automatic t_loaded();
    logic [71:0] e;
    for (int i = 0; i < 9; i++)
      e[i*8 +: 8] = 8'h5a ^ 8'(i * 8'h13);
    run_boot(1'h1, 1'h0, 1'h0, 72000);
    chk("ids", ids, e);
    chk("version", host_interface_version, EICL_VER_LOADED);
    chk("from_eeprom", from_eeprom, 1'h1);
    chk("read_addr", last_addr, 8'ha1);
    chk("word_addr", word_addr, 8'h00);
    chk("bytes_read", sent_cnt, 4'h9);
  endtask : t_loaded

  task automatic t_absent();
    run_boot(1'h0, 1'h0, 1'h0, 12000);
    chk("ids", ids, DEF_IDS);
    chk("version", host_interface_version, EICL_VER_DEFAULT);
    chk("from_eeprom", from_eeprom, 1'h0);
    chk("write_addr", last_addr, 8'ha0);
  endtask : t_absent

  task automatic t_scl_low();
    run_boot(1'h0, 1'h1, 1'h0, 4000);
    chk("ids", ids, DEF_IDS);
    chk("version", host_interface_version, EICL_VER_LOADED);
    chk("traffic", traffic, 1'h0);
  endtask : t_scl_low

  task automatic t_sda_low();
    run_boot(1'h0, 1'h0, 1'h1, 4000);
    chk("version", host_interface_version, EICL_VER_DEFAULT);
    chk("from_eeprom", from_eeprom, 1'h0);
    chk("traffic", traffic, 1'h0);
  endtask : t_sda_low

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : wrap_up

  // Held-low SDA looks like a start to the model, so that case runs last
  initial
  begin
    nrst = 1'h0;
    m_en = 1'h0;
    scl_low = 1'h0;
    sda_low = 1'h0;
    error_cnt = 0;
    cmp_count = 0;
    t_loaded();
    t_absent();
    t_scl_low();
    t_sda_low();
    wrap_up();
  end

  initial
  begin
    // Just beyond the sum of the per-scenario limits
    #760000;
    error_cnt++;
    wrap_up();
  end
endmodule : tb_eicl_loader
